// ==== temp_alarm_pkg.sv ====
// shared constants for the temperature alarm and shutdown block
package temp_alarm_pkg;
    // register byte addresses on the ahb-lite slave
    localparam logic [7:0] OFS_TEMP     = 8'h00;
    localparam logic [7:0] OFS_CONFIG   = 8'h04;
    localparam logic [7:0] OFS_HYST     = 8'h08;
    localparam logic [7:0] OFS_CRIT     = 8'h0C;
    localparam logic [7:0] OFS_LOW      = 8'h10;
    localparam logic [7:0] OFS_HIGH     = 8'h14;
    localparam logic [7:0] OFS_STATUS   = 8'h18;
    localparam logic [7:0] OFS_RESULT   = 8'h1C;
    // configuration byte fields
    localparam int CFG_SHDN = 0;
    localparam int CFG_INT  = 1;
    localparam int CFG_OTP  = 2;
    localparam int CFG_ALP  = 3;
    localparam int CFG_FQ   = 4;
    localparam int CFG_TMO  = 5;
    localparam logic [7:0] CFG_WMASK = 8'h3F;
    // reset values
    localparam logic [7:0]  RST_CONFIG = 8'h00;
    localparam logic [15:0] RST_TEMP   = 16'h0000;
    localparam logic [15:0] RST_HYST   = 16'h0100;
    localparam logic [15:0] RST_CRIT   = 16'h2800;
    localparam logic [15:0] RST_LOW    = 16'h0500;
    localparam logic [15:0] RST_HIGH   = 16'h2000;
    localparam logic [15:0] LIM_MASK   = 16'hFF80;
    // temperature register: flags sit in the low three bits
    localparam logic [15:0] TEMP_MASK  = 16'hFFF8;
    localparam int FLG_LOW  = 0;
    localparam int FLG_HIGH = 1;
    localparam int FLG_CRIT = 2;
    // fault queue depths
    localparam logic [2:0] DEPTH_ONE  = 3'h1;
    localparam logic [2:0] DEPTH_FOUR = 3'h4;
    // fixed upper slave address bits
    localparam logic [2:0] ADDR_FIXED = 3'h4;
    // interrupt-mode arming state
    typedef enum logic [1:0] {
        ARM_FAULT = 2'b00,   // look for high or low fault
        ARM_HIGH  = 2'b01,   // look for drop below high minus hyst
        ARM_LOW   = 2'b10    // look for rise above low plus hyst
    } arm_t;
endpackage

// ==== fault_queue.sv ====
// consecutive-event counter that fires when the configured depth is reached
`timescale 1ns/1ps
module fault_queue (
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       clear,
    input  wire logic       sample,
    input  wire logic       hit,
    input  wire logic [2:0] depth,
    output logic            reached
);
    logic [2:0] cnt_r;     // consecutive hits so far
    logic [2:0] cnt_nxt;

    // count hits on each sample, restart on a miss
    always_comb begin
        cnt_nxt = cnt_r;
        if (clear) begin
            cnt_nxt = 3'h0;
        end else if (sample) begin
            // a completed run starts over, so the opposite event needs its own full run
            if (!hit || reached) begin
                cnt_nxt = 3'h0;
            end else begin
                cnt_nxt = cnt_r + 3'h1;
            end
        end
    end

    // hit on this sample completes the run
    assign reached = sample && hit && !clear && (cnt_r + 3'h1 >= depth);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_r <= 3'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ==== temp_alarm.sv ====
// alarm, overtemperature and shutdown logic with ahb-lite registers
// Function
// (R1) interrupt mode alarms on high and low faults
// (R2) interrupt alarm held until any register read
// (R3) after high clear, re-raise below high minus hyst
// (R4) interrupt raise needs queue-depth consecutive results
// (R5) comparator raises after depth consecutive limit faults
// (R6) comparator drops after depth results inside hysteresis
// (R7) comparator clears alarm without host access
// (R8) alarm polarity and mode configurable, open drain
// (R9) overtemp asserts when result exceeds critical limit
// (R10) overtemp releases below critical minus hysteresis
// (R11) overtemp assert and release use fault queue
// (R12) shutdown bit stops conversions, bus keeps working
// (R13) shutdown keeps last result readable
// (R14) shutdown freezes outputs, holds queue in reset
// (R15) after shutdown old result until next conversion
// (R16) slave address is 100 then four straps
// (R17) mode bit zero comparator, one interrupt
// (R18) polarity bit zero active low, one high
// (R19) queue enable selects depth one or four
// (R20) shutdown bit zero normal; config resets zero
// (R21) after low clear, re-raise above low plus hyst
// (R22) compare once per single-cycle result strobe
`timescale 1ns/1ps
module temp_alarm
    import temp_alarm_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // converter side
    input  wire logic        result_valid,
    input  wire logic [15:0] result_data,
    output logic             conv_enable,
    // serial bus side
    input  wire logic        host_reg_read,
    output logic [6:0]       slave_addr,
    // address straps from pins
    input  wire logic        addr_strap_bit0,
    input  wire logic        addr_strap_bit1,
    input  wire logic        addr_strap_bit2,
    input  wire logic        addr_strap_bit3,
    // open-drain outputs, enable high means pulling low
    output logic             alarm_o,
    output logic             alarm_oe,
    output logic             overtemp_out_o,
    output logic             overtemp_out_oe
);
    import temp_alarm_pkg::*;

    // ---------------- register state ----------------
    logic [7:0]  config_r,  config_nxt;   // configuration byte
    logic [15:0] hyst_r,    hyst_nxt;     // hysteresis
    logic [15:0] crit_r,    crit_nxt;     // critical limit
    logic [15:0] low_r,     low_nxt;      // lower limit
    logic [15:0] high_r,    high_nxt;     // upper limit
    logic [15:0] temp_r,    temp_nxt;     // last result plus flags
    logic        wr_pend_r, wr_pend_nxt;  // data phase of a write
    logic [7:0]  wr_addr_r, wr_addr_nxt;  // address of that write
    logic        rd_strobe_r, rd_strobe_nxt; // read accepted pulse
    logic [31:0] hrdata_r,  hrdata_nxt;   // read data register
    // alarm state
    logic        alarm_act_r, alarm_act_nxt;  // alarm logical level
    logic        ot_act_r,    ot_act_nxt;     // overtemp logical level
    arm_t        arm_r,       arm_nxt;        // interrupt arming
    // synchronisers for straps and host read strobe
    logic [3:0]  strap_s1_r, strap_s2_r;
    logic        hrd_s1_r, hrd_s2_r, hrd_s3_r;
    logic [6:0]  addr_r;

    logic        shdn, int_mode;
    logic [2:0]  depth;
    logic        sample, any_read;
    logic signed [15:0] t, hi, lo, cr, hy;
    logic        above_hi, below_lo, above_cr;
    logic        below_hi_h, above_lo_h, below_cr_h;
    logic        q_fault_hit, q_clear_hit, q_cfire, q_rfire;
    logic        q_ot_hit, q_otr_hit, q_ofire, q_orfire;
    logic        q_rst;
    logic        addr_ok;

    assign shdn     = config_r[CFG_SHDN];            // see (R20)
    assign int_mode = config_r[CFG_INT];             // see (R17)
    assign depth    = config_r[CFG_FQ] ? DEPTH_FOUR : DEPTH_ONE; // see (R19)
    assign conv_enable = !shdn;                      // see (R12)
    // strobe ignored in shutdown; one evaluation per strobe
    assign sample   = result_valid && !shdn;         // see (R22)
    assign q_rst    = shdn;                          // see (R14)

    // signed views of the result and limits
    assign t  = $signed(result_data & TEMP_MASK);
    assign hi = $signed(high_r);
    assign lo = $signed(low_r);
    assign cr = $signed(crit_r);
    assign hy = $signed(hyst_r);

    // limit comparisons; the hysteresis ones widened by sign bit guard
    assign above_hi   = t > hi;
    assign below_lo   = t < lo;
    assign above_cr   = t > cr;                      // see (R9)
    assign below_hi_h = 17'($signed(t)) < 17'(hi - hy);   // see (R3) (R6)
    assign above_lo_h = 17'($signed(t)) > 17'(lo + hy);   // see (R21) (R6)
    assign below_cr_h = 17'($signed(t)) < 17'(cr - hy);   // see (R10)

    // qualifying condition for alarm raise depends on arming
    always_comb begin
        q_fault_hit = 1'b0;
        q_clear_hit = 1'b0;
        if (int_mode) begin
            // counting starts only once the pending alarm is read away
            if (!alarm_act_r) begin
                case (arm_r)
                    ARM_FAULT: q_fault_hit = above_hi || below_lo; // see (R1)
                    ARM_HIGH:  q_fault_hit = below_hi_h;           // see (R3)
                    ARM_LOW:   q_fault_hit = above_lo_h;           // see (R21)
                    default:   q_fault_hit = 1'b0;
                endcase
            end
        end else if (alarm_act_r) begin
            // release only for results back inside the narrowed window
            q_clear_hit = below_hi_h && above_lo_h;            // see (R6)
        end else begin
            q_fault_hit = above_hi || below_lo;                // see (R5)
        end
        q_ot_hit  = !ot_act_r && above_cr;
        q_otr_hit = ot_act_r && below_cr_h;
    end

    // one queue per output, shared by its raise and release conditions
    fault_queue u_q_alarm (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .clear   (q_rst),
        .sample  (sample),
        .hit     (q_fault_hit || q_clear_hit),
        .depth   (depth),
        .reached (q_cfire)
    );
    fault_queue u_q_over (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .clear   (q_rst),
        .sample  (sample),
        .hit     (q_ot_hit || q_otr_hit),
        .depth   (depth),
        .reached (q_ofire)
    );
    assign q_rfire  = q_cfire && q_clear_hit;
    assign q_orfire = q_ofire && q_otr_hit;

    // read of any register, from the bus or the serial side
    assign any_read = rd_strobe_r || (hrd_s2_r && !hrd_s3_r);

    // alarm and overtemp state
    always_comb begin
        alarm_act_nxt = alarm_act_r;
        arm_nxt       = arm_r;
        ot_act_nxt    = ot_act_r;
        if (!shdn) begin                                   // see (R14)
            if (int_mode) begin
                // a fresh fault wins over a same-cycle clearing read
                if (any_read && alarm_act_r) begin         // see (R2)
                    alarm_act_nxt = 1'b0;
                end
                if (q_cfire) begin                         // see (R4)
                    alarm_act_nxt = 1'b1;
                    case (arm_r)
                        ARM_FAULT: arm_nxt = above_hi ? ARM_HIGH : ARM_LOW;
                        ARM_HIGH:  arm_nxt = ARM_FAULT;
                        ARM_LOW:   arm_nxt = ARM_FAULT;
                        default:   arm_nxt = ARM_FAULT;
                    endcase
                end
            end else begin
                arm_nxt = ARM_FAULT;
                if (q_rfire) begin
                    alarm_act_nxt = 1'b0;                  // see (R7)
                end else if (q_cfire) begin
                    alarm_act_nxt = 1'b1;                  // see (R5)
                end
            end
            if (q_orfire) begin
                ot_act_nxt = 1'b0;                         // see (R10) (R11)
            end else if (q_ofire) begin
                ot_act_nxt = 1'b1;                         // see (R9) (R11)
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            alarm_act_r <= 1'b0;
            arm_r       <= ARM_FAULT;
            ot_act_r    <= 1'b0;
        end else begin
            alarm_act_r <= alarm_act_nxt;
            arm_r       <= arm_nxt;
            ot_act_r    <= ot_act_nxt;
        end
    end

    // open drain: pull low when the pin's electrical level is low
    assign alarm_o         = 1'b0;
    assign overtemp_out_o  = 1'b0;
    assign alarm_oe        = !(alarm_act_r ^ !config_r[CFG_ALP]);  // see (R8) (R18)
    assign overtemp_out_oe = !(ot_act_r ^ !config_r[CFG_OTP]);     // see (R18)

    // ---------------- ahb-lite slave ----------------
    assign addr_ok   = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;   // zero wait states
    assign hresp     = 1'b0;   // always okay
    assign hrdata    = hrdata_r;

    // address phase capture, read data and register writes
    always_comb begin
        wr_pend_nxt   = addr_ok && hwrite;
        wr_addr_nxt   = addr_ok ? haddr[7:0] : wr_addr_r;
        rd_strobe_nxt = addr_ok && !hwrite;
        hrdata_nxt    = hrdata_r;
        config_nxt    = config_r;
        hyst_nxt      = hyst_r;
        crit_nxt      = crit_r;
        low_nxt       = low_r;
        high_nxt      = high_r;
        temp_nxt      = temp_r;
        if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                OFS_TEMP:   hrdata_nxt = {16'h0000, temp_r};   // see (R13)
                OFS_CONFIG: hrdata_nxt = {24'h000000, config_r};
                OFS_HYST:   hrdata_nxt = {16'h0000, hyst_r};
                OFS_CRIT:   hrdata_nxt = {16'h0000, crit_r};
                OFS_LOW:    hrdata_nxt = {16'h0000, low_r};
                OFS_HIGH:   hrdata_nxt = {16'h0000, high_r};
                OFS_STATUS: hrdata_nxt = {24'h000000, 1'b0, addr_r};
                OFS_RESULT: hrdata_nxt = {28'h0000000, arm_r, ot_act_r, alarm_act_r};
                default:    hrdata_nxt = 32'h00000000;
            endcase
        end
        if (wr_pend_r) begin
            case (wr_addr_r)
                OFS_CONFIG: config_nxt = hwdata[7:0] & CFG_WMASK;  // see (R12)
                OFS_HYST:   hyst_nxt   = hwdata[15:0] & LIM_MASK;
                OFS_CRIT:   crit_nxt   = hwdata[15:0] & LIM_MASK;
                OFS_LOW:    low_nxt    = hwdata[15:0] & LIM_MASK;
                OFS_HIGH:   high_nxt   = hwdata[15:0] & LIM_MASK;
                default:    config_nxt = config_r;
            endcase
        end
        // new result only while converting; old one held otherwise
        if (sample) begin                                  // see (R15)
            temp_nxt = (result_data & TEMP_MASK)
                     | {13'h0000, above_cr, above_hi, below_lo};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            config_r    <= RST_CONFIG;                     // see (R20)
            hyst_r      <= RST_HYST;
            crit_r      <= RST_CRIT;
            low_r       <= RST_LOW;
            high_r      <= RST_HIGH;
            temp_r      <= RST_TEMP;
            wr_pend_r   <= 1'b0;
            wr_addr_r   <= 8'h00;
            rd_strobe_r <= 1'b0;
            hrdata_r    <= 32'h00000000;
        end else begin
            config_r    <= config_nxt;
            hyst_r      <= hyst_nxt;
            crit_r      <= crit_nxt;
            low_r       <= low_nxt;
            high_r      <= high_nxt;
            temp_r      <= temp_nxt;
            wr_pend_r   <= wr_pend_nxt;
            wr_addr_r   <= wr_addr_nxt;
            rd_strobe_r <= rd_strobe_nxt;
            hrdata_r    <= hrdata_nxt;
        end
    end

    // pin synchronisers; address formed from second stage only
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            strap_s1_r <= 4'h0;
            strap_s2_r <= 4'h0;
            hrd_s1_r   <= 1'b0;
            hrd_s2_r   <= 1'b0;
            hrd_s3_r   <= 1'b0;
            addr_r     <= 7'h00;
        end else begin
            strap_s1_r <= {addr_strap_bit3, addr_strap_bit2,
                           addr_strap_bit1, addr_strap_bit0};
            strap_s2_r <= strap_s1_r;
            hrd_s1_r   <= host_reg_read;
            hrd_s2_r   <= hrd_s1_r;
            hrd_s3_r   <= hrd_s2_r;
            addr_r     <= {ADDR_FIXED, strap_s2_r};        // see (R16)
        end
    end
    assign slave_addr = addr_r;
endmodule

// ==== temp_alarm_checker.sv ====
// port-level assertions for the temperature alarm block
`timescale 1ns/1ps
module temp_alarm_checker (
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       result_valid,
    input wire logic       conv_enable,
    input wire logic       host_reg_read,
    input wire logic [6:0] slave_addr,
    input wire logic       addr_strap_bit0,
    input wire logic       addr_strap_bit1,
    input wire logic       addr_strap_bit2,
    input wire logic       addr_strap_bit3,
    input wire logic       alarm_o,
    input wire logic       alarm_oe,
    input wire logic       overtemp_out_o,
    input wire logic       overtemp_out_oe
);
    import temp_alarm_pkg::*;
    logic [3:0] quiet_r, quiet_nxt;   // cycles since any cause of an output change
    logic       hrr_r, hrr_nxt;       // last serial read level
    logic [3:0] strap;                // straps, most significant first
    assign strap = {addr_strap_bit3, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
    // quiet counter saturates so long idle spans stay cheap
    always_comb begin
        hrr_nxt   = host_reg_read;
        quiet_nxt = (quiet_r == 4'hF) ? quiet_r : quiet_r + 4'h1;
        if (result_valid || hsel || (host_reg_read != hrr_r)) begin
            quiet_nxt = 4'h0;
        end
    end
    always_ff @(posedge ref_clk) begin
        quiet_r <= sys_rst ? 4'h0 : quiet_nxt;
        hrr_r   <= hrr_nxt;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    property p_open_drain;
        !alarm_o && !overtemp_out_o;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin data not low");
    property p_addr_fixed;
        !$past(sys_rst) |-> slave_addr[6:4] == ADDR_FIXED;
    endproperty
    a_addr_fixed: assert property (p_addr_fixed) else $error("fixed address bits");
    property p_addr_straps;
        $stable(strap) [*5] |-> slave_addr[3:0] == strap;
    endproperty
    a_addr_straps: assert property (p_addr_straps) else $error("strap address bits");
    property p_freeze;
        !conv_enable [*3] |-> $stable(alarm_oe) && $stable(overtemp_out_oe);
    endproperty
    a_freeze: assert property (p_freeze) else $error("output moved in shutdown");
    property p_conv_write;
        $changed(conv_enable) |-> $past(hsel && htrans[1] && hwrite, 2);
    endproperty
    a_conv_write: assert property (p_conv_write) else $error("enable moved alone");
    property p_quiet;
        quiet_r > 4'h5 |-> $stable(alarm_oe) && $stable(overtemp_out_oe);
    endproperty
    a_quiet: assert property (p_quiet) else $error("output moved with no cause");
    property p_reset_state;
        $past(sys_rst) |-> conv_enable && !alarm_oe && !overtemp_out_oe;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("state after reset");
    property p_bus_alive;
        !conv_enable |-> hreadyout && !hresp;
    endproperty
    a_bus_alive: assert property (p_bus_alive) else $error("bus stalled in shutdown");
endmodule
bind temp_alarm temp_alarm_checker i_temp_alarm_checker (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hreadyout(hreadyout), .hresp(hresp), .result_valid(result_valid),
    .conv_enable(conv_enable), .host_reg_read(host_reg_read), .slave_addr(slave_addr),
    .addr_strap_bit0(addr_strap_bit0), .addr_strap_bit1(addr_strap_bit1),
    .addr_strap_bit2(addr_strap_bit2), .addr_strap_bit3(addr_strap_bit3),
    .alarm_o(alarm_o), .alarm_oe(alarm_oe), .overtemp_out_o(overtemp_out_o),
    .overtemp_out_oe(overtemp_out_oe)
);

// ==== far_side_model.sv ====
// stand-in for the converter and the serial host that reads registers
`timescale 1ns/1ps
module far_side_model (
    input  wire logic   ref_clk,
    output logic        result_valid,
    output logic [15:0] result_data,
    output logic        host_reg_read
);
    initial begin
        result_valid  = 1'b0;
        result_data   = 16'h0000;
        host_reg_read = 1'b0;
    end
    // single-cycle strobe; data inverted afterwards so stale values never match
    task automatic convert(input logic [15:0] value);
        @(posedge ref_clk);
        result_valid <= 1'b1;
        result_data  <= value;
        @(posedge ref_clk);
        result_valid <= 1'b0;
        result_data  <= ~value;
    endtask
    // one register read, high for half a 160 ns link period
    task automatic host_read();
        @(posedge ref_clk);
        host_reg_read <= 1'b1;
        #80;
        @(posedge ref_clk);
        host_reg_read <= 1'b0;
        #80;
    endtask
endmodule

// ==== tb_top.sv ====
// self-checking bench for the temperature alarm block
`timescale 1ns/1ps
module tb_top;
    import temp_alarm_pkg::*;
    logic        ref_clk, sys_rst, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        result_valid, conv_enable, host_reg_read;
    logic [15:0] result_data;
    logic [6:0]  slave_addr;
    logic [3:0]  strap;
    logic        alarm_o, alarm_oe, overtemp_out_o, overtemp_out_oe;
    int          num_errors, samples_checked;
    wire         alarm_pin = alarm_oe ? alarm_o : 1'b1;            // board pull-up
    wire         ot_pin    = overtemp_out_oe ? overtemp_out_o : 1'b1;
    temp_alarm i_temp_alarm (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .result_valid(result_valid), .result_data(result_data), .conv_enable(conv_enable),
        .host_reg_read(host_reg_read), .slave_addr(slave_addr),
        .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
        .addr_strap_bit2(strap[2]), .addr_strap_bit3(strap[3]),
        .alarm_o(alarm_o), .alarm_oe(alarm_oe), .overtemp_out_o(overtemp_out_o),
        .overtemp_out_oe(overtemp_out_oe)
    );
    far_side_model i_far_side_model (
        .ref_clk(ref_clk), .result_valid(result_valid), .result_data(result_data),
        .host_reg_read(host_reg_read)
    );
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic compare_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic compare_pin(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: pin %b, wanted %b", $time, got, exp);
        end
    endtask
    // single ahb-lite word; read data lands in rdata
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        rdata = hrdata;
    endtask
    // outputs follow a cause within a few cycles
    task automatic settle();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
    task automatic conv_chk(input logic [15:0] v, input logic a, input logic o);
        i_far_side_model.convert(v);
        settle();
        compare_pin(alarm_pin, a);
        compare_pin(ot_pin, o);
    endtask
    // reset raised on a rising edge and held for three sampled edges
    task automatic do_reset();
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
    endtask
    task automatic s_reset_values();
        logic [7:0]  ofs [7] = '{OFS_TEMP, OFS_CONFIG, OFS_HYST, OFS_CRIT, OFS_LOW,
                                 OFS_HIGH, 8'h20};
        logic [31:0] val [7] = '{{16'h0000, RST_TEMP}, {24'h000000, RST_CONFIG},
                                 {16'h0000, RST_HYST}, {16'h0000, RST_CRIT},
                                 {16'h0000, RST_LOW}, {16'h0000, RST_HIGH}, 32'h0};
        for (int i = 0; i < 7; i++) begin
            ahb(1'b0, ofs[i], 32'h0);
            compare_word(rdata, val[i]);
        end
        compare_pin(alarm_pin, 1'b1);
        compare_pin(ot_pin, 1'b1);
        strap <= 4'hA;
        repeat (6) @(posedge ref_clk);
        ahb(1'b0, OFS_STATUS, 32'h0);
        compare_word(rdata, {25'h0, ADDR_FIXED, 4'hA});
    endtask
    task automatic s_comparator();
        conv_chk(16'h2100, 1'b0, 1'b1);
        conv_chk(16'h2900, 1'b0, 1'b0);
        conv_chk(16'h2780, 1'b0, 1'b0);
        conv_chk(16'h2600, 1'b0, 1'b1);
        conv_chk(16'h1F80, 1'b0, 1'b1);
        conv_chk(16'h1E00, 1'b1, 1'b1);
        conv_chk(16'h0400, 1'b0, 1'b1);
        conv_chk(16'h0600, 1'b0, 1'b1);
        conv_chk(16'h0680, 1'b1, 1'b1);
        ahb(1'b0, OFS_TEMP, 32'h0);
        compare_word(rdata & {16'h0000, TEMP_MASK}, 32'h0680);
    endtask
    task automatic s_queue();
        ahb(1'b1, OFS_CONFIG, 32'h10);
        for (int i = 0; i < 3; i++) conv_chk(16'h2900, 1'b1, 1'b1);
        conv_chk(16'h2900, 1'b0, 1'b0);
        for (int i = 0; i < 3; i++) conv_chk(16'h1E00, 1'b0, 1'b0);
        conv_chk(16'h1E00, 1'b1, 1'b1);
    endtask
    task automatic s_interrupt();
        do_reset();
        ahb(1'b1, OFS_CONFIG, 32'h02);
        conv_chk(16'h2100, 1'b0, 1'b1);
        i_far_side_model.host_read();
        settle();
        compare_pin(alarm_pin, 1'b1);
        conv_chk(16'h2100, 1'b1, 1'b1);
        conv_chk(16'h1E00, 1'b0, 1'b1);
        ahb(1'b0, OFS_TEMP, 32'h0);
        settle();
        compare_pin(alarm_pin, 1'b1);
        conv_chk(16'h0400, 1'b0, 1'b1);
        i_far_side_model.host_read();
        settle();
        compare_pin(alarm_pin, 1'b1);
        conv_chk(16'h0580, 1'b1, 1'b1);
        conv_chk(16'h0680, 1'b0, 1'b1);
        ahb(1'b0, OFS_RESULT, 32'h0);
        compare_word(rdata, {28'h0, ARM_FAULT, 1'b0, 1'b1});
    endtask
    task automatic s_polarity();
        do_reset();
        ahb(1'b1, OFS_CONFIG, 32'h0C);
        settle();
        compare_pin(alarm_pin, 1'b0);
        compare_pin(ot_pin, 1'b0);
        conv_chk(16'h2900, 1'b1, 1'b1);
    endtask
    task automatic s_shutdown();
        do_reset();
        conv_chk(16'h2100, 1'b0, 1'b1);
        ahb(1'b1, OFS_CONFIG, 32'h01);
        settle();
        compare_pin(conv_enable, 1'b0);
        conv_chk(16'h1000, 1'b0, 1'b1);
        ahb(1'b0, OFS_TEMP, 32'h0);
        compare_word(rdata & {16'h0000, TEMP_MASK}, 32'h2100);
        ahb(1'b1, OFS_CONFIG, 32'h00);
        ahb(1'b0, OFS_TEMP, 32'h0);
        compare_word(rdata & {16'h0000, TEMP_MASK}, 32'h2100);
        compare_pin(conv_enable, 1'b1);
        conv_chk(16'h1000, 1'b1, 1'b1);
        ahb(1'b0, OFS_TEMP, 32'h0);
        compare_word(rdata & {16'h0000, TEMP_MASK}, 32'h1000);
    endtask
    task automatic results();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        strap = 4'h5;
        num_errors = 0;
        samples_checked = 0;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        s_reset_values();
        s_comparator();
        s_queue();
        s_interrupt();
        s_polarity();
        s_shutdown();
        results();
    end
    // watchdog well beyond the expected run length
    initial begin
        #100000;
        num_errors++;
        results();
    end
endmodule
